// *** src/hsfs_pkg.sv ***
// Package for the high-side fault shutdown control block.
// Assumes one 100 MHz clock and a register port of 7-bit address, 16-bit data.
package hsfs_pkg;

    // ************************************************************
    // Register map
    // ************************************************************
    localparam int unsigned NUM_SW = 4;
    localparam int unsigned ADDR_W = 7;
    localparam int unsigned DATA_W = 16;
    localparam logic [6:0] CFG_ADDR = 7'h07;
    localparam logic [15:0] CFG_RESET = 16'h0000;
    // Writable bits; bit 4 and bits 2:0 are reserved
    localparam logic [15:0] CFG_WR_MASK = 16'hFFE8;

    // ************************************************************
    // Field positions
    // ************************************************************
    localparam int unsigned OV_REC_LSB = 12;
    localparam int unsigned OT_SCOPE_BIT = 11;
    localparam int unsigned OV_INH_NORM_LSB = 7;
    localparam int unsigned OV_INH_LP_BIT = 6;
    localparam int unsigned UV_INH_BIT = 5;
    localparam int unsigned UV_REC_BIT = 3;

    // ************************************************************
    // Per-switch shutdown states
    // ************************************************************
    typedef enum logic [4:0] {
        ST_RUN    = 5'b0_0001,
        ST_OFF_OV = 5'b0_0010,
        ST_OFF_UV = 5'b0_0100,
        ST_OFF_OT = 5'b0_1000,
        ST_LATCH  = 5'b1_0000
    } hsfs_state_type;

endpackage

// *** src/hsfs_switch_cell.sv ***
// Shutdown state machine for one high-side output.
// Assumes fault hit inputs are already synchronised and gated by policy.
`timescale 1ns/1ps
`default_nettype none
module hsfs_switch_cell (
    // Clock and reset
    input wire logic sys_clk_i,
    input wire logic reset_i,
    // Synchronised fault levels and policy-gated fault hits
    input wire logic ov_i,
    input wire logic ov_hit_i,
    input wire logic uv_i,
    input wire logic uv_hit_i,
    input wire logic ot_active_i,
    input wire logic ot_hit_i,
    // Recovery policy
    input wire logic ov_recover_i,
    input wire logic uv_recover_i,
    // Normally selected switch state
    input wire logic sel_on_i,
    // State and override
    output hsfs_pkg::hsfs_state_type state_o,
    output logic forced_off_o
);

    hsfs_pkg::hsfs_state_type state_ff;
    hsfs_pkg::hsfs_state_type nxt_state;

    // ************************************************************
    // Next state
    // ************************************************************
    always_comb begin
        nxt_state = state_ff;
        case (state_ff)
            hsfs_pkg::ST_RUN: begin
                // Thermal wins, then undervoltage, then overvoltage
                if (ot_hit_i) begin
                    nxt_state = hsfs_pkg::ST_OFF_OT;
                end else if (uv_hit_i) begin
                    nxt_state = hsfs_pkg::ST_OFF_UV;
                end else if (ov_hit_i) begin
                    nxt_state = hsfs_pkg::ST_OFF_OV;
                end
            end
            hsfs_pkg::ST_OFF_OV: begin
                if (ot_hit_i) begin
                    nxt_state = hsfs_pkg::ST_OFF_OT;
                end else if (!ov_i) begin
                    nxt_state = ov_recover_i ? hsfs_pkg::ST_RUN : hsfs_pkg::ST_LATCH;
                end
            end
            hsfs_pkg::ST_OFF_UV: begin
                if (ot_hit_i) begin
                    nxt_state = hsfs_pkg::ST_OFF_OT;
                end else if (!uv_i) begin
                    nxt_state = uv_recover_i ? hsfs_pkg::ST_RUN : hsfs_pkg::ST_LATCH;
                end
            end
            hsfs_pkg::ST_OFF_OT: begin
                // No thermal recovery option: latches once the fault clears, then off until the host deselects
                if (!ot_active_i) begin
                    nxt_state = hsfs_pkg::ST_LATCH;
                end
            end
            hsfs_pkg::ST_LATCH: begin
                if (!sel_on_i) begin
                    nxt_state = hsfs_pkg::ST_RUN;
                end
            end
            default: begin
                nxt_state = hsfs_pkg::ST_RUN;
            end
        endcase
    end

    always_ff @(posedge sys_clk_i) begin
        if (reset_i) begin
            state_ff <= hsfs_pkg::ST_RUN;
        end else begin
            state_ff <= nxt_state;
        end
    end

    assign state_o = state_ff;
    assign forced_off_o = (state_ff != hsfs_pkg::ST_RUN);

endmodule
`default_nettype wire

// *** src/hsfs_ctrl.sv ***
// High-side fault shutdown control: configuration register and fault policy.
// Assumes fault detector outputs are asynchronous pins, mode and selection
// come from same-clock logic, register accesses are single-cycle strobes.
// Operation
// - Per-switch overvoltage recovery restores or latches off
// - Thermal scope bit: all switches or affected only
// - Normal mode per-switch overvoltage shutdown inhibit
// - Low-power modes share one overvoltage inhibit
// - One undervoltage shutdown inhibit for all switches
// - Shared undervoltage recovery restores or latches off
// - Reserved bits read-only, always zero
`timescale 1ns/1ps
`default_nettype none
module hsfs_ctrl #(
    parameter int unsigned NUM_SW = hsfs_pkg::NUM_SW
) (
    // Clock and resets
    input wire logic sys_clk_i,
    input wire logic reset_i,
    input wire logic restart_i,
    // Register port
    input wire logic reg_wr_i,
    input wire logic reg_rd_i,
    input wire logic [hsfs_pkg::ADDR_W-1:0] reg_addr_i,
    input wire logic [hsfs_pkg::DATA_W-1:0] reg_wdata_i,
    output logic [hsfs_pkg::DATA_W-1:0] reg_rdata_o,
    // Fault detectors
    input wire logic ov_i,
    input wire logic uv_i,
    input wire logic [NUM_SW-1:0] ot_i,
    // Mode and selection
    input wire logic normal_mode_i,
    input wire logic [NUM_SW-1:0] sel_on_i,
    // Switch drive
    output logic [NUM_SW-1:0] forced_off_o,
    output logic [NUM_SW-1:0] out_on_o
);

    // ************************************************************
    // Configuration register
    // ************************************************************
    logic [hsfs_pkg::DATA_W-1:0] cfg_ff;
    logic [hsfs_pkg::DATA_W-1:0] nxt_cfg;
    logic [hsfs_pkg::DATA_W-1:0] rdata_ff;
    logic [hsfs_pkg::DATA_W-1:0] nxt_rdata;
    logic hit_addr;

    assign hit_addr = (reg_addr_i == hsfs_pkg::CFG_ADDR);

    always_comb begin
        nxt_cfg = cfg_ff;
        nxt_rdata = rdata_ff;
        if (restart_i) begin
            nxt_cfg = cfg_ff & hsfs_pkg::CFG_WR_MASK;
        end else if (reg_wr_i && hit_addr) begin
            nxt_cfg = reg_wdata_i & hsfs_pkg::CFG_WR_MASK;
        end
        if (reg_rd_i) begin
            nxt_rdata = hit_addr ? (cfg_ff & hsfs_pkg::CFG_WR_MASK) : '0;
        end
    end

    always_ff @(posedge sys_clk_i) begin
        if (reset_i) begin
            cfg_ff <= hsfs_pkg::CFG_RESET;
            rdata_ff <= '0;
        end else begin
            cfg_ff <= nxt_cfg;
            rdata_ff <= nxt_rdata;
        end
    end

    assign reg_rdata_o = rdata_ff;

    // ************************************************************
    // Fault input synchronisers
    // ************************************************************
    localparam int unsigned SYNC_W = NUM_SW + 2;
    logic [SYNC_W-1:0] sync1_ff;
    logic [SYNC_W-1:0] sync2_ff;
    logic ov_s;
    logic uv_s;
    logic [NUM_SW-1:0] ot_s;

    always_ff @(posedge sys_clk_i) begin
        if (reset_i) begin
            sync1_ff <= '0;
            sync2_ff <= '0;
        end else begin
            sync1_ff <= {ot_i, uv_i, ov_i};
            sync2_ff <= sync1_ff;
        end
    end

    assign ov_s = sync2_ff[0];
    assign uv_s = sync2_ff[1];
    assign ot_s = sync2_ff[SYNC_W-1:2];

    // ************************************************************
    // Fault policy
    // ************************************************************
    logic ot_scope;
    logic ov_inh_lp;
    logic uv_inh;
    logic uv_rec;
    logic ot_any;
    logic [NUM_SW-1:0] ov_rec;
    logic [NUM_SW-1:0] ov_inh_norm;
    logic [NUM_SW-1:0] ov_hit;
    logic [NUM_SW-1:0] uv_hit;
    logic [NUM_SW-1:0] ot_hit;
    logic [NUM_SW-1:0] forced_off;
    logic [NUM_SW-1:0] out_on_ff;
    logic [NUM_SW-1:0] nxt_out_on;
    hsfs_pkg::hsfs_state_type sw_state [NUM_SW];

    assign ot_scope = cfg_ff[hsfs_pkg::OT_SCOPE_BIT];
    assign ov_inh_lp = cfg_ff[hsfs_pkg::OV_INH_LP_BIT];
    assign uv_inh = cfg_ff[hsfs_pkg::UV_INH_BIT];
    assign uv_rec = cfg_ff[hsfs_pkg::UV_REC_BIT];
    assign ov_rec = cfg_ff[hsfs_pkg::OV_REC_LSB +: NUM_SW];
    assign ov_inh_norm = cfg_ff[hsfs_pkg::OV_INH_NORM_LSB +: NUM_SW];
    assign ot_any = |ot_s;

    always_comb begin
        for (int i = 0; i < NUM_SW; i++) begin
            // Normal mode uses per-switch inhibit, stop and sleep the shared one
            ov_hit[i] = ov_s && (normal_mode_i ? !ov_inh_norm[i] : !ov_inh_lp);
            uv_hit[i] = uv_s && !uv_inh;
            ot_hit[i] = ot_scope ? ot_s[i] : ot_any;
        end
    end

    for (genvar g = 0; g < NUM_SW; g++) begin : g_sw
        hsfs_switch_cell u_cell (
            .sys_clk_i(sys_clk_i),
            .reset_i(reset_i),
            .ov_i(ov_s),
            .ov_hit_i(ov_hit[g]),
            .uv_i(uv_s),
            .uv_hit_i(uv_hit[g]),
            .ot_active_i(ot_scope ? ot_s[g] : ot_any),
            .ot_hit_i(ot_hit[g]),
            .ov_recover_i(ov_rec[g]),
            .uv_recover_i(uv_rec),
            .sel_on_i(sel_on_i[g]),
            .state_o(sw_state[g]),
            .forced_off_o(forced_off[g])
        );
    end

    // ************************************************************
    // Output override
    // ************************************************************
    always_comb begin
        nxt_out_on = sel_on_i & ~forced_off;
    end

    always_ff @(posedge sys_clk_i) begin
        if (reset_i) begin
            out_on_ff <= '0;
        end else begin
            out_on_ff <= nxt_out_on;
        end
    end

    assign out_on_o = out_on_ff;
    assign forced_off_o = forced_off;

    // ************************************************************
    // Assertions
    // ************************************************************
    default clocking cb @(posedge sys_clk_i);
    endclocking
    default disable iff (reset_i);

    a_res_zero: assert property ((cfg_ff & ~hsfs_pkg::CFG_WR_MASK) == '0 &&
        (reg_rdata_o & ~hsfs_pkg::CFG_WR_MASK) == '0)
        else $error("Reserved bits not zero");

    a_restart_keep: assert property (restart_i |=> cfg_ff == $past(cfg_ff))
        else $error("Restart changed configuration");

    a_write_read: assert property (reg_wr_i && hit_addr && !restart_i ##1 reg_rd_i && hit_addr && !reg_wr_i
        |=> reg_rdata_o == ($past(reg_wdata_i, 2) & hsfs_pkg::CFG_WR_MASK))
        else $error("Read-back differs from write");

    for (genvar a = 0; a < NUM_SW; a++) begin : g_chk
        sequence s_ov_gone;
            sw_state[a] == hsfs_pkg::ST_OFF_OV && !ov_s && !ot_hit[a];
        endsequence

        sequence s_uv_gone;
            sw_state[a] == hsfs_pkg::ST_OFF_UV && !uv_s && !ot_hit[a];
        endsequence

        a_ov_recover: assert property (s_ov_gone |=>
            sw_state[a] == ($past(ov_rec[a]) ? hsfs_pkg::ST_RUN : hsfs_pkg::ST_LATCH))
            else $error("Overvoltage recovery wrong");

        a_ot_all: assert property (!ot_scope && ot_any && sw_state[a] == hsfs_pkg::ST_RUN
            |=> sw_state[a] == hsfs_pkg::ST_OFF_OT ##1 !out_on_o[a])
            else $error("Global thermal shutdown missed");

        a_ot_indiv: assert property (ot_scope && !ot_s[a] && sw_state[a] == hsfs_pkg::ST_RUN
            && !uv_hit[a] && !ov_hit[a] |=> sw_state[a] == hsfs_pkg::ST_RUN)
            else $error("Unaffected switch shut down");

        a_ov_normal: assert property (normal_mode_i && ov_s && !ot_hit[a] && !uv_hit[a]
            && sw_state[a] == hsfs_pkg::ST_RUN |=> sw_state[a] ==
            ($past(ov_inh_norm[a]) ? hsfs_pkg::ST_RUN : hsfs_pkg::ST_OFF_OV))
            else $error("Normal mode overvoltage response wrong");

        a_ov_lowpwr: assert property (!normal_mode_i && ov_s && !ot_hit[a] && !uv_hit[a]
            && sw_state[a] == hsfs_pkg::ST_RUN |=> sw_state[a] ==
            ($past(ov_inh_lp) ? hsfs_pkg::ST_RUN : hsfs_pkg::ST_OFF_OV))
            else $error("Low-power overvoltage response wrong");

        a_uv_off: assert property (uv_s && !ot_hit[a] && sw_state[a] == hsfs_pkg::ST_RUN
            |=> sw_state[a] == ($past(uv_inh) ?
            ($past(ov_hit[a]) ? hsfs_pkg::ST_OFF_OV : hsfs_pkg::ST_RUN) : hsfs_pkg::ST_OFF_UV))
            else $error("Undervoltage response wrong");

        a_uv_recover: assert property (s_uv_gone |=>
            sw_state[a] == ($past(uv_rec) ? hsfs_pkg::ST_RUN : hsfs_pkg::ST_LATCH))
            else $error("Undervoltage recovery wrong");

        a_forced_out: assert property (forced_off[a] |=> !out_on_o[a])
            else $error("Forced-off switch still driven");
    end

endmodule
`default_nettype wire

// *** tb/hsfs_host_model.sv ***
// Host model: drives the configuration register port of the shutdown block.
// Assumes the bench clock; strobes are one cycle wide and taken on the rising edge.
`timescale 1ns/1ps
`default_nettype none
module hsfs_host_model (
    // Clock
    input wire logic sys_clk_i,
    // Register port
    output logic reg_wr_o,
    output logic reg_rd_o,
    output logic [6:0] reg_addr_o,
    output logic [15:0] reg_wdata_o,
    input wire logic [15:0] reg_rdata_i
);
    // ****************************************
    // Register cycles
    // ****************************************
    initial begin
        reg_wr_o = 1'b0;
        reg_rd_o = 1'b0;
        reg_addr_o = 7'h00;
        reg_wdata_o = 16'h0000;
    end

    task automatic write_reg(input logic [6:0] addr, input logic [15:0] data);
        @(negedge sys_clk_i);
        reg_wr_o = 1'b1;
        reg_addr_o = addr;
        reg_wdata_o = data;
        @(negedge sys_clk_i);
        reg_wr_o = 1'b0;
        // Released bus shows the inverse, never a stale copy
        reg_wdata_o = ~data;
    endtask

    // Write and read back on consecutive edges
    task automatic write_read(input logic [6:0] addr, input logic [15:0] wdata, output logic [15:0] data);
        @(negedge sys_clk_i);
        reg_wr_o = 1'b1;
        reg_addr_o = addr;
        reg_wdata_o = wdata;
        @(negedge sys_clk_i);
        reg_wr_o = 1'b0;
        reg_wdata_o = ~wdata;
        reg_rd_o = 1'b1;
        @(negedge sys_clk_i);
        reg_rd_o = 1'b0;
        reg_addr_o = ~addr;
        data = reg_rdata_i;
    endtask

    task automatic read_reg(input logic [6:0] addr, output logic [15:0] data);
        @(negedge sys_clk_i);
        reg_rd_o = 1'b1;
        reg_addr_o = addr;
        @(negedge sys_clk_i);
        reg_rd_o = 1'b0;
        reg_addr_o = ~addr;
        data = reg_rdata_i;
    endtask
endmodule
`default_nettype wire

// *** tb/hsfs_ctrl_tb.sv ***
// Self-checking bench for the high-side fault shutdown control block.
// Assumes the host model speaks the register port; faults driven on falling edges.
`timescale 1ns/1ps
`default_nettype none
module hsfs_ctrl_tb;
    logic sys_clk_i;
    logic reset_i;
    logic restart_i;
    logic reg_wr;
    logic reg_rd;
    logic [6:0] reg_addr;
    logic [15:0] reg_wdata;
    logic [15:0] reg_rdata;
    logic [15:0] rd_val;
    logic [15:0] d;
    logic ov_i;
    logic uv_i;
    logic normal_mode_i;
    logic [3:0] ot_i;
    logic [3:0] sel_on_i;
    logic [3:0] forced_off_o;
    logic [3:0] out_on_o;
    int fail_count = 0;
    int cmp_count = 0;

    hsfs_ctrl #(.NUM_SW(4)) u_dut (
        .sys_clk_i(sys_clk_i), .reset_i(reset_i), .restart_i(restart_i),
        .reg_wr_i(reg_wr), .reg_rd_i(reg_rd), .reg_addr_i(reg_addr),
        .reg_wdata_i(reg_wdata), .reg_rdata_o(reg_rdata),
        .ov_i(ov_i), .uv_i(uv_i), .ot_i(ot_i),
        .normal_mode_i(normal_mode_i), .sel_on_i(sel_on_i),
        .forced_off_o(forced_off_o), .out_on_o(out_on_o)
    );

    hsfs_host_model u_host (
        .sys_clk_i(sys_clk_i), .reg_wr_o(reg_wr), .reg_rd_o(reg_rd),
        .reg_addr_o(reg_addr), .reg_wdata_o(reg_wdata), .reg_rdata_i(reg_rdata)
    );

    initial begin
        sys_clk_i = 1'b0;
        forever #5 sys_clk_i = ~sys_clk_i;
    end

    // ****************************************
    // Checking and expectations
    // ****************************************
    task automatic check(input logic [15:0] got, input logic [15:0] exp);
        cmp_count++;
        if (got !== exp) begin
            fail_count++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic end_sim();
        if (fail_count == 0 && cmp_count > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask

    // Kind 0 overvoltage, 1 undervoltage, 2 overtemperature
    function automatic logic [3:0] exp_off(input logic [15:0] c, input logic nm, input logic [1:0] k,
                                           input logic [3:0] ot);
        if (k == 2'd2) return c[11] ? ot : 4'hF;
        if (k == 2'd1) return c[5] ? 4'h0 : 4'hF;
        return nm ? ~c[10:7] : (c[6] ? 4'h0 : 4'hF);
    endfunction

    // Thermal off has no recovery bit, so it always latches
    function automatic logic [3:0] exp_rest(input logic [15:0] c, input logic [1:0] k, input logic [3:0] off);
        if (k == 2'd2) return off;
        if (k == 2'd1) return c[3] ? 4'h0 : off;
        return off & ~c[15:12];
    endfunction

    task automatic fault_case(input logic [15:0] c, input logic nm, input logic [1:0] k, input logic [3:0] ot);
        logic [3:0] off;
        off = exp_off(c, nm, k, ot);
        u_host.write_reg(7'h07, c);
        @(negedge sys_clk_i);
        normal_mode_i = nm;
        ov_i = (k == 2'd0);
        uv_i = (k == 2'd1);
        ot_i = (k == 2'd2) ? ot : 4'h0;
        repeat (6) @(negedge sys_clk_i);
        check(16'(forced_off_o), 16'(off));
        check(16'(out_on_o), 16'(sel_on_i & ~off));
        ov_i = 1'b0;
        uv_i = 1'b0;
        ot_i = 4'h0;
        repeat (6) @(negedge sys_clk_i);
        check(16'(forced_off_o), 16'(exp_rest(c, k, off)));
        sel_on_i = 4'h0;
        repeat (6) @(negedge sys_clk_i);
        check(16'(forced_off_o), 16'h0000);
        sel_on_i = 4'hF;
        repeat (6) @(negedge sys_clk_i);
    endtask

    // ****************************************
    // Main sequence
    // ****************************************
    initial begin
        reset_i = 1'b1;
        restart_i = 1'b0;
        ov_i = 1'b0;
        uv_i = 1'b0;
        ot_i = 4'h0;
        normal_mode_i = 1'b1;
        sel_on_i = 4'hF;
        d = 16'($urandom(7));
        repeat (3) @(posedge sys_clk_i);
        @(negedge sys_clk_i);
        reset_i = 1'b0;
        u_host.read_reg(7'h07, rd_val);
        check(rd_val, 16'h0000);
        for (int i = 0; i < 16; i++) begin
            d = 16'($urandom);
            u_host.write_reg(7'h07, d);
            u_host.write_reg(7'($urandom_range(8, 127)), ~d);
            u_host.read_reg(7'h07, rd_val);
            check(rd_val, d & 16'hFFE8);
            u_host.write_read(7'h07, ~d, rd_val);
            check(rd_val, ~d & 16'hFFE8);
        end
        // Restart keeps writable bits and blocks writes
        u_host.write_reg(7'h07, 16'hFFFF);
        restart_i = 1'b1;
        u_host.write_reg(7'h07, 16'h0000);
        restart_i = 1'b0;
        u_host.read_reg(7'h07, rd_val);
        check(rd_val, 16'hFFE8);
        @(negedge sys_clk_i);
        reset_i = 1'b1;
        @(negedge sys_clk_i);
        reset_i = 1'b0;
        u_host.read_reg(7'h07, rd_val);
        check(rd_val, 16'h0000);
        fault_case(16'h0000, 1'b1, 2'd0, 4'h0);
        fault_case(16'hA000, 1'b1, 2'd0, 4'h0);
        fault_case(16'h0500, 1'b1, 2'd0, 4'h0);
        fault_case(16'h0780, 1'b0, 2'd0, 4'h0);
        fault_case(16'h0040, 1'b0, 2'd0, 4'h0);
        fault_case(16'h0000, 1'b1, 2'd1, 4'h0);
        fault_case(16'h0008, 1'b0, 2'd1, 4'h0);
        fault_case(16'h0020, 1'b1, 2'd1, 4'h0);
        fault_case(16'h0000, 1'b1, 2'd2, 4'h2);
        fault_case(16'h0800, 1'b1, 2'd2, 4'h9);
        for (int i = 0; i < 12; i++) begin
            fault_case(16'($urandom), 1'($urandom), 2'($urandom_range(0, 2)), 4'($urandom_range(1, 15)));
        end
        end_sim();
    end

    // Hang guard
    initial begin
        #200_000;
        fail_count++;
        end_sim();
    end
endmodule
`default_nettype wire
